// ---- core/charger_emulation_timing_config.sv ----
// timing and profile configuration registers of the port controller
`timescale 1ns/100ps
module charger_emulation_timing_config (
   // clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            reset_n,
   // management bus register port
   input  wire charger_timing_pkg::reg_req_type reg_req,
   output logic [7:0]                           reg_rdata,
   // power and sleep state
   input  wire logic                            sleep_state,
   input  wire logic                            over_temp,
   input  wire logic                            bus_discharged,
   input  wire logic                            bypass_on,
   input  wire logic                            device_present,
   input  wire logic                            port_power_enable,
   // mode pins
   input  wire logic                            mode_select_a,
   input  wire logic                            mode_select_b,
   input  wire logic                            emulation_enable_ctl,
   input  wire logic                            emulation_timeout_disable,
   // profile request from the emulation engine
   input  wire charger_timing_pkg::prof_req_type prof_req,
   // outputs
   output logic                                 limit_hold,
   output logic                                 attach_eval_enable,
   output logic                                 removal_report,
   output logic                                 attach_report,
   output logic                                 profile_included,
   output logic                                 timeout_valid,
   output logic [31:0]                          emulation_timeout
);
   typedef struct packed {
      logic [7:0]  delay_cfg;
      logic [7:0]  std_enable;
      logic [7:0]  leg_enable;
      logic [7:0]  std_timeout;
      logic [7:0]  leg_to_a;
      logic [7:0]  leg_to_b;
      logic [7:0]  rdata;
      logic        over_temp_q;
      logic        settle_cond_q;
      logic        settle_wait;
      logic        limit_hold;
      logic        attach_eval;
      logic        removal;
      logic        attach;
      logic        included;
      logic        to_valid;
      logic [31:0] timeout;
   } cfg_state_type;

   cfg_state_type state;
   cfg_state_type next_state;

   logic [6:0] pins;
   logic       s_temp, s_disch, s_bypass, s_present, s_pwr, s_ma, s_mb;
   logic       cool_start, cool_run, settle_start, settle_run, settle_done;
   logic [31:0] cool_len, settle_len;

   // pins from outside the clock domain pass two flops first
   pin_sync #(.WIDTH(7)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({over_temp, bus_discharged, bypass_on, device_present,
                  port_power_enable, mode_select_a, mode_select_b}),
      .sync_out (pins)
   );
   assign {s_temp, s_disch, s_bypass, s_present, s_pwr, s_ma, s_mb} = pins;

   // 2^sel steps of the base cool-down time
   function automatic logic [31:0] cool_cycles(input logic [1:0] sel);
      cool_cycles = 32'(charger_timing_pkg::BASE_CYC) << sel;
   endfunction : cool_cycles

   function automatic logic [31:0] settle_cycles(input logic [2:0] sel);
      if (sel == 3'h7)
         settle_cycles = 32'(charger_timing_pkg::SETTLE_MAX_CYC);
      else
         settle_cycles = 32'(charger_timing_pkg::STEP_CYC) * ({29'h0, sel}
                         + 32'h1);
   endfunction : settle_cycles

   // 00/01/10/11 -> 1x/2x/8x/16x of 0.8 s
   function automatic logic [31:0] to_cycles(input logic [1:0] sel);
      logic [31:0] base;
      base = 32'(charger_timing_pkg::TIMEOUT_CYC);
      unique case (sel)
         2'h0: to_cycles = base;
         2'h1: to_cycles = base << 1;
         2'h2: to_cycles = base << 3;
         2'h3: to_cycles = base << 4;
      endcase
   endfunction : to_cycles

   assign cool_len   = cool_cycles(state.delay_cfg[4:3]);
   assign settle_len = settle_cycles(state.delay_cfg[2:0]);
   assign cool_start   = s_temp && !state.over_temp_q;
   assign settle_start = s_disch && s_bypass && !state.settle_cond_q;

   delay_timer u_cool (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .start    (cool_start),
      .length   (cool_len),
      .running  (cool_run),
      .done     ()
   );

   delay_timer u_settle (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .start    (settle_start),
      .length   (settle_len),
      .running  (settle_run),
      .done     (settle_done)
   );

   always_comb begin
      logic       dedicated_mode;
      logic [1:0] sel;
      logic [7:0] wd;
      dedicated_mode = 1'b0;
      sel = 2'h0;
      wd = reg_req.wdata;
      next_state = state;
      next_state.over_temp_q   = s_temp;
      next_state.settle_cond_q = s_disch && s_bypass;
      next_state.limit_hold    = cool_run || cool_start;
      next_state.removal = 1'b0;
      next_state.attach  = 1'b0;
      // sleep never touches the registers below
      if (reg_req.write) begin
         unique case (reg_req.addr)
            charger_timing_pkg::OFS_DELAY_CFG:
               next_state.delay_cfg = wd & charger_timing_pkg::MSK_DELAY_CFG;
            charger_timing_pkg::OFS_STD_ENABLE:
               next_state.std_enable = wd & charger_timing_pkg::MSK_STD_ENABLE;
            charger_timing_pkg::OFS_LEG_ENABLE:
               next_state.leg_enable = wd & charger_timing_pkg::MSK_LEG_ENABLE;
            charger_timing_pkg::OFS_STD_TIMEOUT:
               next_state.std_timeout =
                  wd & charger_timing_pkg::MSK_STD_TIMEOUT;
            charger_timing_pkg::OFS_LEG_TO_A:
               next_state.leg_to_a = wd & charger_timing_pkg::MSK_LEG_TO_A;
            charger_timing_pkg::OFS_LEG_TO_B:
               next_state.leg_to_b = wd & charger_timing_pkg::MSK_LEG_TO_B;
            default: ;
         endcase
      end
      unique case (reg_req.addr)
         charger_timing_pkg::OFS_DELAY_CFG:   next_state.rdata = state.delay_cfg;
         charger_timing_pkg::OFS_STD_ENABLE:  next_state.rdata = state.std_enable;
         charger_timing_pkg::OFS_LEG_ENABLE:  next_state.rdata = state.leg_enable;
         charger_timing_pkg::OFS_STD_TIMEOUT: next_state.rdata = state.std_timeout;
         charger_timing_pkg::OFS_LEG_TO_A:    next_state.rdata = state.leg_to_a;
         charger_timing_pkg::OFS_LEG_TO_B:    next_state.rdata = state.leg_to_b;
         default:                             next_state.rdata = 8'h00;
      endcase
      if (!reg_req.read)
         next_state.rdata = state.rdata;
      // attach detection waits for the settle timer
      if (settle_start) begin
         next_state.attach_eval = 1'b0;
         next_state.settle_wait = 1'b1;
      end else if (settle_done) begin
         next_state.attach_eval = 1'b1;
         next_state.settle_wait = 1'b0;
         // long settle lets a present device look unplugged
         if (settle_len > 32'(charger_timing_pkg::REMOVAL_CYC)
             && s_present && !s_pwr) begin
            next_state.removal = 1'b1;
            next_state.attach  = 1'b1;
         end
      end
      // mode pins: a high, b high and enable low picks dedicated mode
      dedicated_mode = s_ma && s_mb && !emulation_enable_ctl;
      next_state.included = 1'b0;
      next_state.to_valid = 1'b0;
      if (prof_req.apply) begin
         if (prof_req.profile == charger_timing_pkg::PROF_DEDICATED) begin
            next_state.included = dedicated_mode ||
               !state.std_enable[charger_timing_pkg::DEDICATED_DIS_BIT];
            sel = state.std_timeout[5:4];
         end else if (prof_req.profile >= charger_timing_pkg::PROF_LEGACY_1 &&
                      prof_req.profile <= charger_timing_pkg::PROF_LEGACY_7) begin
            next_state.included =
               !state.leg_enable[3'(prof_req.profile - 4'h3)];
            unique case (prof_req.profile)
               4'h3: sel = state.leg_to_a[7:6];
               4'h4: sel = state.leg_to_a[5:4];
               4'h5: sel = state.leg_to_a[3:2];
               4'h6: sel = state.leg_to_a[1:0];
               4'h7: sel = state.leg_to_b[5:4];
               4'h8: sel = state.leg_to_b[3:2];
               default: sel = state.leg_to_b[1:0];
            endcase
         end
         next_state.to_valid = !emulation_timeout_disable;
         next_state.timeout  = emulation_timeout_disable ? 32'h0
                               : to_cycles(sel);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state             <= '0;
         state.delay_cfg   <= charger_timing_pkg::RST_DELAY_CFG;
         state.std_enable  <= charger_timing_pkg::RST_STD_ENABLE;
         state.leg_enable  <= charger_timing_pkg::RST_LEG_ENABLE;
         state.std_timeout <= charger_timing_pkg::RST_STD_TIMEOUT;
         state.leg_to_a    <= charger_timing_pkg::RST_LEG_TO_A;
         state.leg_to_b    <= charger_timing_pkg::RST_LEG_TO_B;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata          = state.rdata;
   assign limit_hold         = state.limit_hold;
   assign attach_eval_enable = state.attach_eval;
   assign removal_report     = state.removal;
   assign attach_report      = state.attach;
   assign profile_included   = state.included;
   assign timeout_valid      = state.to_valid;
   assign emulation_timeout  = state.timeout;

   AST_UNIMPL_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
      state.leg_enable[7] == 1'b0 && state.leg_to_b[7:6] == 2'h0)
      else $error("unimplemented bit set");
   AST_SLEEP_KEEP: assert property (@(posedge core_clk) disable iff (!reset_n)
      sleep_state && !reg_req.write |=> $stable(state.delay_cfg))
      else $error("config lost in sleep");
   AST_HOLD_COOL: assert property (@(posedge core_clk) disable iff (!reset_n)
      cool_start |=> ##1 limit_hold)
      else $error("limit not held");
   AST_NO_EARLY_ATTACH: assert property (@(posedge core_clk) disable iff (!reset_n)
      settle_start |=> !attach_eval_enable [*8])
      else $error("attach evaluated early");
   AST_REMOVAL_PAIR: assert property (@(posedge core_clk) disable iff (!reset_n)
      removal_report |-> attach_report)
      else $error("removal without attach");
   AST_DED_SKIP: assert property (@(posedge core_clk) disable iff (!reset_n)
      prof_req.apply && prof_req.profile == charger_timing_pkg::PROF_DEDICATED
      && state.std_enable[4] && !(s_ma && s_mb && !emulation_enable_ctl)
      |=> !profile_included)
      else $error("disabled profile included");
   AST_DED_MODE: assert property (@(posedge core_clk) disable iff (!reset_n)
      prof_req.apply && prof_req.profile == charger_timing_pkg::PROF_DEDICATED
      && s_ma && s_mb && !emulation_enable_ctl |=> profile_included)
      else $error("dedicated mode skipped");
   AST_TO_DISABLE: assert property (@(posedge core_clk) disable iff (!reset_n)
      prof_req.apply && emulation_timeout_disable |=> !timeout_valid)
      else $error("timeout used while disabled");
   COV_ATTACH: cover property (@(posedge core_clk) settle_done);
   COV_REMOVAL: cover property (@(posedge core_clk) removal_report);
   COV_PROFILE: cover property (@(posedge core_clk) timeout_valid);
endmodule : charger_emulation_timing_config

// ---- core/delay_timer.sv ----
// loadable down counter with a done pulse
`timescale 1ns/100ps
module delay_timer (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // control
   input  wire logic        start,
   input  wire logic [31:0] length,
   // status
   output logic             running,
   output logic             done
);
   typedef struct packed {
      logic [31:0] count;
      logic        running;
      logic        done;
   } timer_state_type;

   timer_state_type state;
   timer_state_type next_state;

   always_comb begin
      next_state      = state;
      next_state.done = 1'b0;
      if (start) begin
         next_state.count   = length;
         next_state.running = 1'b1;
      end else if (state.running) begin
         if (state.count <= 32'h1) begin
            next_state.running = 1'b0;
            next_state.done    = 1'b1;
            next_state.count   = 32'h0;
         end else begin
            next_state.count = state.count - 32'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign running = state.running;
   assign done    = state.done;
endmodule : delay_timer

// ---- core/pin_sync.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   always_comb begin
      next_state.first  = async_in;
      next_state.second = state.first;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.second;
endmodule : pin_sync

// ---- dv/portable_device.sv ----
// portable device model standing on the usb port
`timescale 1ns/100ps
module portable_device (
   // clock
   input  wire logic core_clk,
   // plug control from the bench
   input  wire logic plugged,
   // port level
   output logic      device_present
);
   initial device_present = 1'b0;
   // presence only moves on the falling edge, away from the sampling edge
   always @(negedge core_clk) begin
      device_present <= plugged;
   end
endmodule : portable_device

// ---- dv/tb.sv ----
// self-checking bench of the charger emulation timing registers
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) begin \
         error_cnt++; \
         $display("[FAIL] %s exp %h got %h", nm, ex, got); \
      end \
   end
module tb;
   logic                             core_clk = 1'b0;
   logic                             reset_n = 1'b0;
   charger_timing_pkg::reg_req_type  req = '0;
   charger_timing_pkg::prof_req_type preq = '0;
   logic [7:0]                       reg_rdata;
   logic                             sleep_state = 1'b0;
   logic                             over_temp = 1'b0;
   logic                             bus_discharged = 1'b0;
   logic                             bypass_on = 1'b0;
   logic                             device_present;
   logic                             plugged = 1'b0;
   logic                             port_power_enable = 1'b0;
   logic                             mode_a = 1'b0;
   logic                             mode_b = 1'b0;
   logic                             emu_en = 1'b1;
   logic                             to_dis = 1'b0;
   logic                             limit_hold;
   logic                             attach_eval_enable;
   logic                             removal_report;
   logic                             attach_report;
   logic                             profile_included;
   logic                             timeout_valid;
   logic [31:0]                      emulation_timeout;
   int                               error_cnt = 0;
   int                               n_compared = 0;
   logic [7:0]                       shadow [6];
   logic [7:0]                       rmask [6];
   logic [7:0]                       d;

   always #5 core_clk = ~core_clk;

   portable_device partner (
      .core_clk       (core_clk),
      .plugged        (plugged),
      .device_present (device_present)
   );

   charger_emulation_timing_config dut (
      .core_clk                  (core_clk),
      .reset_n                   (reset_n),
      .reg_req                   (req),
      .reg_rdata                 (reg_rdata),
      .sleep_state               (sleep_state),
      .over_temp                 (over_temp),
      .bus_discharged            (bus_discharged),
      .bypass_on                 (bypass_on),
      .device_present            (device_present),
      .port_power_enable         (port_power_enable),
      .mode_select_a             (mode_a),
      .mode_select_b             (mode_b),
      .emulation_enable_ctl      (emu_en),
      .emulation_timeout_disable (to_dis),
      .prof_req                  (preq),
      .limit_hold                (limit_hold),
      .attach_eval_enable        (attach_eval_enable),
      .removal_report            (removal_report),
      .attach_report             (attach_report),
      .profile_included          (profile_included),
      .timeout_valid             (timeout_valid),
      .emulation_timeout         (emulation_timeout)
   );

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req.write = 1'b1;
      req.addr = a;
      req.wdata = v;
      tick(1);
      req.write = 1'b0;
      if (a >= 8'h1f && a <= 8'h24) shadow[a - 8'h1f] = v & rmask[a - 8'h1f];
   endtask : wr

   // rdata holds until the next read, so two edges cover either latency
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      req.read = 1'b1;
      req.addr = a;
      tick(1);
      req.read = 1'b0;
      tick(1);
      v = reg_rdata;
   endtask : rd

   task automatic prof(input int p, output logic inc, output logic vld,
                       output logic [31:0] t);
      inc = 1'b0;
      vld = 1'b0;
      t = '0;
      preq.apply = 1'b1;
      preq.profile = 4'(p);
      tick(1);
      preq.apply = 1'b0;
      repeat (3) begin
         if (profile_included === 1'b1) inc = 1'b1;
         if (timeout_valid === 1'b1) begin
            vld = 1'b1;
            t = emulation_timeout;
         end
         tick(1);
      end
   endtask : prof

   function automatic logic [31:0] to_cyc(input logic [1:0] c);
      int ms [4] = '{800, 1600, 6400, 12800};
      return 32'(ms[c] * charger_timing_pkg::CLK_KHZ);
   endfunction : to_cyc

   task automatic s_reset();
      logic [7:0] rv [6] = '{8'h03, 8'h16, 8'h00, 8'h10, 8'h6c, 8'h01};
      for (int i = 0; i < 6; i++) begin
         rd(8'h1f + 8'(i), d);
         `CHK("reset value", rv[i], d);
         shadow[i] = rv[i];
      end
      `CHK("limit_hold at reset", 1'b0, limit_hold);
   endtask : s_reset

   task automatic s_mask();
      for (int i = 0; i < 6; i++) begin
         wr(8'h1f + 8'(i), 8'hff);
         rd(8'h1f + 8'(i), d);
         `CHK("masked ones", rmask[i], d);
         wr(8'h1f + 8'(i), 8'h00);
         rd(8'h1f + 8'(i), d);
         `CHK("zeros", 8'h00, d);
      end
      wr(8'h25, 8'hff);
      rd(8'h25, d);
      `CHK("unmapped", 8'h00, d);
   endtask : s_mask

   // walks all profile codes against the shadows of the enables and timeouts
   task automatic s_profiles();
      logic        inc;
      logic        vld;
      logic        exi;
      logic [1:0]  c;
      logic [31:0] t;
      for (int p = 2; p <= 9; p++) begin
         exi = (p == 2) ? !shadow[1][4] : !shadow[2][p-3];
         c = (p == 2) ? shadow[3][5:4] :
             (p < 7) ? shadow[4][(6-p)*2 +: 2] : shadow[5][(9-p)*2 +: 2];
         prof(p, inc, vld, t);
         `CHK("included", exi, inc);
         if (exi) begin
            `CHK("timeout valid", 1'b1, vld);
            `CHK("timeout", to_cyc(c), t);
         end
      end
   endtask : s_profiles

   task automatic s_config();
      logic        inc;
      logic        vld;
      logic [31:0] t;
      wr(8'h20, 8'h16);
      wr(8'h22, 8'h10);
      rd(8'h22, d);
      wr(8'h22, (d & 8'h0f) | 8'h30);
      wr(8'h21, 8'h55);
      wr(8'h23, 8'h1b);
      wr(8'h24, 8'h24);
      s_profiles();
      rd(8'h20, d);
      wr(8'h20, d & 8'hef);
      rd(8'h20, d);
      `CHK("reserved kept", 8'h06, d);
      wr(8'h21, 8'h2a);
      s_profiles();
      wr(8'h20, 8'h16);
      mode_a = 1'b1;
      mode_b = 1'b1;
      emu_en = 1'b0;
      tick(6);
      prof(2, inc, vld, t);
      `CHK("dedicated mode", 1'b1, inc);
      mode_a = 1'b0;
      mode_b = 1'b0;
      emu_en = 1'b1;
      to_dis = 1'b1;
      prof(4, inc, vld, t);
      `CHK("timeout disabled valid", 1'b0, vld);
      `CHK("timeout disabled", 32'h0, emulation_timeout);
      to_dis = 1'b0;
   endtask : s_config

   // only the start of the long timers fits in the run
   task automatic s_timers();
      int n;
      wr(8'h1f, 8'h1f);
      over_temp = 1'b1;
      n = 0;
      while (limit_hold !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      `CHK("cooldown started", 1'b1, limit_hold);
      over_temp = 1'b0;
      tick(200);
      `CHK("limit held", 1'b1, limit_hold);
      plugged = 1'b1;
      bus_discharged = 1'b1;
      bypass_on = 1'b1;
      tick(300);
      `CHK("no early attach eval", 1'b0, attach_eval_enable);
      `CHK("no early removal", 1'b0, removal_report);
      `CHK("no early attach", 1'b0, attach_report);
   endtask : s_timers

   task automatic s_sleep();
      sleep_state = 1'b1;
      tick(8);
      for (int i = 0; i < 6; i++) begin
         rd(8'h1f + 8'(i), d);
         `CHK("sleep retention", shadow[i], d);
      end
      sleep_state = 1'b0;
   endtask : s_sleep

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      results();
   end

   initial begin
      rmask = '{8'h1f, 8'h17, 8'h7f, 8'h3f, 8'hff, 8'h3f};
      tick(20);
      reset_n = 1'b1;
      tick(1);
      s_reset();
      s_mask();
      s_config();
      s_timers();
      s_sleep();
      results();
   end
endmodule : tb

// ---- inc/charger_timing_pkg.sv ----
// shared constants and types for the charger emulation timing block
package charger_timing_pkg;

   // register offsets
   localparam logic [7:0] OFS_DELAY_CFG   = 8'h1f;
   localparam logic [7:0] OFS_STD_ENABLE  = 8'h20;
   localparam logic [7:0] OFS_LEG_ENABLE  = 8'h21;
   localparam logic [7:0] OFS_STD_TIMEOUT = 8'h22;
   localparam logic [7:0] OFS_LEG_TO_A    = 8'h23;
   localparam logic [7:0] OFS_LEG_TO_B    = 8'h24;

   // reset values
   localparam logic [7:0] RST_DELAY_CFG   = 8'h03;
   localparam logic [7:0] RST_STD_ENABLE  = 8'h16;
   localparam logic [7:0] RST_LEG_ENABLE  = 8'h00;
   localparam logic [7:0] RST_STD_TIMEOUT = 8'h10;
   localparam logic [7:0] RST_LEG_TO_A    = 8'h6c;
   localparam logic [7:0] RST_LEG_TO_B    = 8'h01;

   // writable bit masks, unimplemented bits are zero
   localparam logic [7:0] MSK_DELAY_CFG   = 8'h1f;
   localparam logic [7:0] MSK_STD_ENABLE  = 8'h17;
   localparam logic [7:0] MSK_LEG_ENABLE  = 8'h7f;
   localparam logic [7:0] MSK_STD_TIMEOUT = 8'h3f;
   localparam logic [7:0] MSK_LEG_TO_A    = 8'hff;
   localparam logic [7:0] MSK_LEG_TO_B    = 8'h3f;

   // field positions
   localparam int COOLDOWN_SEL_LSB  = 3;
   localparam int SETTLE_SEL_LSB    = 0;
   localparam int DEDICATED_DIS_BIT = 4;
   localparam int DEDICATED_TO_LSB  = 4;

   // times in ms and cycles at 100 MHz
   localparam int CLK_KHZ        = 100000;
   localparam int COOLDOWN_MS    = 200;
   localparam int SETTLE_STEP_MS = 200;
   localparam int SETTLE_MAX_MS  = 2000;
   localparam int REMOVAL_MS     = 800;
   localparam int TIMEOUT_MS     = 800;
   localparam int BASE_CYC       = COOLDOWN_MS * CLK_KHZ;
   localparam int STEP_CYC       = SETTLE_STEP_MS * CLK_KHZ;
   localparam int SETTLE_MAX_CYC = SETTLE_MAX_MS * CLK_KHZ;
   localparam int REMOVAL_CYC    = REMOVAL_MS * CLK_KHZ;
   localparam int TIMEOUT_CYC    = TIMEOUT_MS * CLK_KHZ;

   // profile codes of the emulation cycle
   localparam logic [3:0] PROF_DEDICATED = 4'h2;
   localparam logic [3:0] PROF_LEGACY_1  = 4'h3;
   localparam logic [3:0] PROF_LEGACY_7  = 4'h9;

   // management bus write / read request
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   // profile requested by the emulation engine
   typedef struct packed {
      logic       apply;
      logic [3:0] profile;
   } prof_req_type;

endpackage : charger_timing_pkg
